// ### src/dis_pkg.sv
// Constants shared by the display instruction sequencer
`default_nettype none
package dis_pkg;
    // Register port byte offsets
    localparam logic [3:0] REG_START_OFS = 4'h0;
    localparam logic [3:0] REG_STATUS_OFS = 4'h4;
    localparam logic [3:0] REG_PC_OFS = 4'h8;
    // Status register field positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SECOND_BIT = 1;
    localparam int ST_CONT_BIT = 2;
    localparam int ST_JUMP_BIT = 3;
    localparam int ST_CTRL_LSB = 4;
    localparam int ST_DATA_LSB = 8;
    localparam int ST_LINE_LSB = 12;
    localparam int ST_INT_LSB = 16;
    localparam int ST_BLINK_BIT = 20;
    localparam int ST_PEN_BIT = 21;
    // Instruction word fields
    localparam int INSTR_BIT = 15;
    localparam int DATA_MODE_SEL_BIT = 14;
    localparam int MODE_MSB = 13;
    localparam int MODE_LSB = 11;
    localparam logic [4:0] OP_JUMP = 5'h1c;
    localparam logic [4:0] OP_NOP = 5'h1d;
    localparam logic [2:0] CTRL_GRAPHIC = 3'h0;
    localparam logic [2:0] CTRL_NOP = 3'h5;
    // Set-graphic-mode parameter bits
    localparam int PEN_INTERRUPT_ENABLE_BIT = 10;
    localparam int GM_INT_MSB = 9;
    localparam int GM_INT_LSB = 7;
    localparam int GM_PEN_ENA_BIT = 6;
    localparam int GM_PEN_VAL_BIT = 5;
    localparam int BLINK_ENABLE_FLAG_BIT = 4;
    localparam int GM_BLINK_VAL_BIT = 3;
    localparam int GM_LINE_ENA_BIT = 2;
    localparam int GM_LINE_HIGH_BIT = 1;
    localparam int GM_LINE_LOW_BIT = 0;
    // Reset values and program counter step
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [3:0] LINE_PRESET = 4'hf;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [2:0] INT_RESET = 3'h0;
    localparam logic [15:0] PC_STEP = 16'h0002;
    // Step-two pulse length
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TWO_NS = 50;
    localparam int STEP_TWO_CYC = (STEP_TWO_NS / CLK_PERIOD_NS < 1) ? 1 :
        STEP_TWO_NS / CLK_PERIOD_NS;
    // Timing sequence states
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT = 6'h02,
        ST_LMODE = 6'h04,
        ST_LPULSE = 6'h08,
        ST_TP1 = 6'h10,
        ST_TP2 = 6'h20
    } dis_state_t;
endpackage
`default_nettype wire

// ### src/dis_sequencer.sv
// Display instruction fetch, decode and line pattern sequencer
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none
module dis_sequencer #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Memory fetch side
    output logic dma_req_o,
    output logic [ADDR_W-1:0] bus_addr_o,
    input wire logic fetch_word_valid_i,
    input wire logic [15:0] bus_data_i,
    // Vector drawing side
    input wire logic line_counter_preset_i,
    input wire logic vector_step_clock_i,
    input wire logic vector_intensity_flag_i,
    // Decode and parameter outputs
    output logic jump_decoded_o,
    output logic nop_decoded_o,
    output logic graphic_mode_decoded_o,
    output logic [6:0] data_mode_o,
    output logic control_word_flag_o,
    output logic second_word_flag_o,
    output logic line_select_low_o,
    output logic line_select_high_o,
    output logic blink_enable_flag_o,
    output logic pen_interrupt_enable_o,
    output logic [2:0] intensity_o,
    output logic intensity_level_o
);
    if (ADDR_W != 16) begin : g_addr_w_check
        $error("ADDR_W must be 16");
    end
    // Input synchronisers
    logic [1:0] valid_sync_q;
    logic valid_prev_q;
    logic [15:0] data_s1_q;
    logic [15:0] data_s2_q;
    logic [1:0] preset_sync_q;
    logic preset_prev_q;
    logic [1:0] step_sync_q;
    logic step_prev_q;
    logic [1:0] vint_sync_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_sync_q <= 2'h0;
            valid_prev_q <= 1'b0;
            data_s1_q <= 16'h0000;
            data_s2_q <= 16'h0000;
            preset_sync_q <= 2'h0;
            preset_prev_q <= 1'b0;
            step_sync_q <= 2'h0;
            step_prev_q <= 1'b0;
            vint_sync_q <= 2'h0;
        end else begin
            valid_sync_q <= {valid_sync_q[0], fetch_word_valid_i};
            valid_prev_q <= valid_sync_q[1];
            data_s1_q <= bus_data_i;
            data_s2_q <= data_s1_q;
            preset_sync_q <= {preset_sync_q[0], line_counter_preset_i};
            preset_prev_q <= preset_sync_q[1];
            step_sync_q <= {step_sync_q[0], vector_step_clock_i};
            step_prev_q <= step_sync_q[1];
            vint_sync_q <= {vint_sync_q[0], vector_intensity_flag_i};
        end
    end
    logic valid_rise;
    logic preset_rise;
    logic step_rise;
    assign valid_rise = valid_sync_q[1] & ~valid_prev_q;
    assign preset_rise = preset_sync_q[1] & ~preset_prev_q;
    assign step_rise = step_sync_q[1] & ~step_prev_q;

    // Timing sequence
    dis_pkg::dis_state_t state_q;
    logic [1:0] tp2_cnt_q;
    logic [15:0] word_q;
    logic start_wr;
    logic tp2_last;
    assign start_wr = reg_wr_i && reg_addr_i == dis_pkg::REG_START_OFS;
    assign tp2_last = state_q == dis_pkg::ST_TP2 &&
        tp2_cnt_q == 2'(dis_pkg::STEP_TWO_CYC - 1);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= dis_pkg::ST_IDLE;
            tp2_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                dis_pkg::ST_IDLE: begin
                    if (start_wr) begin
                        state_q <= dis_pkg::ST_TP2;
                    end
                end
                dis_pkg::ST_WAIT: begin
                    if (valid_rise) begin
                        state_q <= dis_pkg::ST_LMODE;
                    end
                end
                dis_pkg::ST_LMODE: state_q <= dis_pkg::ST_LPULSE;
                dis_pkg::ST_LPULSE: state_q <= dis_pkg::ST_TP1;
                dis_pkg::ST_TP1: state_q <= dis_pkg::ST_TP2;
                dis_pkg::ST_TP2: begin
                    if (tp2_last) begin
                        state_q <= dis_pkg::ST_WAIT;
                    end
                end
                default: state_q <= dis_pkg::ST_IDLE;
            endcase
            if (state_q == dis_pkg::ST_TP2 && !tp2_last) begin
                tp2_cnt_q <= tp2_cnt_q + 2'h1;
            end else begin
                tp2_cnt_q <= 2'h0;
            end
        end
    end

    // Fetched word capture
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_q <= 16'h0000;
        end else if (state_q == dis_pkg::ST_WAIT && valid_rise) begin
            word_q <= data_s2_q;
        end
    end

    // DMA request, one per sequence
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_req_o <= 1'b0;
        end else if ((state_q == dis_pkg::ST_TP1) ||
                (state_q == dis_pkg::ST_IDLE && start_wr)) begin
            dma_req_o <= 1'b1;
        end else if (state_q == dis_pkg::ST_WAIT && valid_rise) begin
            dma_req_o <= 1'b0;
        end
    end

    // Mode registers and flags
    logic [2:0] ctrl_mode_q;
    logic [2:0] data_mode_q;
    logic jump_target_phase;
    logic is_instr;
    assign jump_target_phase = second_word_flag_o & jump_decoded_o;
    assign is_instr = word_q[dis_pkg::INSTR_BIT];

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_mode_q <= dis_pkg::MODE_RESET;
            data_mode_q <= dis_pkg::MODE_RESET;
            control_word_flag_o <= 1'b0;
            jump_decoded_o <= 1'b0;
        end else if (state_q == dis_pkg::ST_LMODE && !jump_target_phase) begin
            jump_decoded_o <= is_instr &&
                word_q[15:11] == dis_pkg::OP_JUMP;
            if (is_instr && !word_q[dis_pkg::DATA_MODE_SEL_BIT]) begin
                ctrl_mode_q <= dis_pkg::CTRL_GRAPHIC;
                data_mode_q <= word_q[dis_pkg::MODE_MSB:dis_pkg::MODE_LSB];
                control_word_flag_o <= 1'b1;
            end else if (is_instr) begin
                ctrl_mode_q <= word_q[dis_pkg::MODE_MSB:dis_pkg::MODE_LSB];
                control_word_flag_o <= 1'b1;
            end else begin
                control_word_flag_o <= 1'b0;
            end
        end
    end

    // Second-word flag
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            second_word_flag_o <= 1'b0;
        end else if (state_q == dis_pkg::ST_LMODE && is_instr && !jump_target_phase) begin
            second_word_flag_o <= 1'b0;
        end else if (tp2_last && jump_decoded_o) begin
            second_word_flag_o <= !second_word_flag_o;
        end
    end

    // Display program counter
    logic [15:0] display_program_counter_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            display_program_counter_q <= dis_pkg::PC_RESET;
        end else if (state_q == dis_pkg::ST_IDLE && start_wr) begin
            display_program_counter_q <= {reg_wdata_i[15:1], 1'b0};
        end else if (state_q == dis_pkg::ST_LPULSE && jump_target_phase) begin
            display_program_counter_q <= {word_q[15:1], 1'b0};
        end else if (state_q == dis_pkg::ST_TP1 && !jump_target_phase) begin
            display_program_counter_q <= display_program_counter_q +
                dis_pkg::PC_STEP;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_addr_o <= dis_pkg::PC_RESET;
        end else if (state_q == dis_pkg::ST_TP1 || (state_q == dis_pkg::ST_IDLE && start_wr)) begin
            bus_addr_o <= (state_q != dis_pkg::ST_TP1) ? {reg_wdata_i[15:1], 1'b0} :
                (jump_target_phase ? display_program_counter_q :
                display_program_counter_q + dis_pkg::PC_STEP);
        end
    end

    // Mode decode outputs
    logic [2:0] sel_mode;
    assign sel_mode = control_word_flag_o ? ctrl_mode_q : data_mode_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            graphic_mode_decoded_o <= 1'b0;
            nop_decoded_o <= 1'b0;
        end else begin
            graphic_mode_decoded_o <= control_word_flag_o &&
                sel_mode == dis_pkg::CTRL_GRAPHIC;
            nop_decoded_o <= control_word_flag_o && sel_mode == dis_pkg::CTRL_NOP;
        end
    end

    for (genvar m = 0; m < 7; m++) begin : g_data_mode
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                data_mode_o[m] <= 1'b0;
            end else begin
                data_mode_o[m] <= !control_word_flag_o &&
                    sel_mode == 3'(m);
            end
        end
    end

    // Graphic-mode parameters
    logic gm_load;
    assign gm_load = state_q == dis_pkg::ST_LPULSE && !jump_target_phase &&
        control_word_flag_o && ctrl_mode_q == dis_pkg::CTRL_GRAPHIC && is_instr;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            intensity_o <= dis_pkg::INT_RESET;
            line_select_low_o <= 1'b0;
            line_select_high_o <= 1'b0;
            blink_enable_flag_o <= 1'b0;
            pen_interrupt_enable_o <= 1'b0;
        end else if (gm_load) begin
            if (word_q[dis_pkg::PEN_INTERRUPT_ENABLE_BIT]) begin
                intensity_o <= word_q[dis_pkg::GM_INT_MSB:dis_pkg::GM_INT_LSB];
            end
            if (word_q[dis_pkg::BLINK_ENABLE_FLAG_BIT]) begin
                blink_enable_flag_o <= word_q[dis_pkg::GM_BLINK_VAL_BIT];
            end
            if (word_q[dis_pkg::GM_PEN_ENA_BIT]) begin
                pen_interrupt_enable_o <= word_q[dis_pkg::GM_PEN_VAL_BIT];
            end
            if (word_q[dis_pkg::GM_LINE_ENA_BIT]) begin
                line_select_low_o <= word_q[dis_pkg::GM_LINE_LOW_BIT];
                line_select_high_o <= word_q[dis_pkg::GM_LINE_HIGH_BIT];
            end
        end
    end

    // Line counter and pattern
    logic [3:0] line_cnt_q;
    logic half_q;
    logic pattern;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_cnt_q <= dis_pkg::LINE_PRESET;
            half_q <= 1'b0;
        end else if (preset_rise) begin
            line_cnt_q <= dis_pkg::LINE_PRESET;
            half_q <= 1'b0;
        end else if (step_rise) begin
            half_q <= !half_q;
            if (half_q) begin
                line_cnt_q <= line_cnt_q - 4'h1;
            end
        end
    end

    always_comb begin
        case ({line_select_high_o, line_select_low_o})
            2'h0: pattern = 1'b1;
            2'h1: pattern = line_cnt_q[3];
            2'h2: pattern = line_cnt_q[2];
            default: pattern = (line_cnt_q[1] & line_cnt_q[0] & ~line_cnt_q[2]) |
                ~line_cnt_q[3];
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            intensity_level_o <= 1'b0;
        end else begin
            intensity_level_o <= vint_sync_q[1] & pattern;
        end
    end

    // Register read port
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
            case (reg_addr_i)
                dis_pkg::REG_STATUS_OFS: begin
                    reg_rdata_o[dis_pkg::ST_BUSY_BIT] <= state_q != dis_pkg::ST_IDLE;
                    reg_rdata_o[dis_pkg::ST_SECOND_BIT] <= second_word_flag_o;
                    reg_rdata_o[dis_pkg::ST_CONT_BIT] <= control_word_flag_o;
                    reg_rdata_o[dis_pkg::ST_JUMP_BIT] <= jump_decoded_o;
                    reg_rdata_o[dis_pkg::ST_CTRL_LSB +: 3] <= ctrl_mode_q;
                    reg_rdata_o[dis_pkg::ST_DATA_LSB +: 3] <= data_mode_q;
                    reg_rdata_o[dis_pkg::ST_LINE_LSB +: 4] <= line_cnt_q;
                    reg_rdata_o[dis_pkg::ST_INT_LSB +: 3] <= intensity_o;
                    reg_rdata_o[dis_pkg::ST_BLINK_BIT] <= blink_enable_flag_o;
                    reg_rdata_o[dis_pkg::ST_PEN_BIT] <= pen_interrupt_enable_o;
                end
                dis_pkg::REG_PC_OFS: reg_rdata_o[15:0] <= display_program_counter_q;
                default: reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_jump_first_mode;
        state_q == dis_pkg::ST_LMODE && !jump_target_phase && is_instr &&
            word_q[15:11] == dis_pkg::OP_JUMP;
    endsequence
    sequence s_target_load;
        state_q == dis_pkg::ST_LPULSE && jump_target_phase;
    endsequence

    a_jump_decode: assert property (s_jump_first_mode |=> jump_decoded_o &&
        ctrl_mode_q == word_q[13:11] && !second_word_flag_o)
        else $error("jump first word not decoded");
    a_word_clear: assert property (state_q == dis_pkg::ST_LMODE && is_instr &&
        !jump_target_phase |=> !second_word_flag_o)
        else $error("second-word flag not cleared");
    a_pc_step: assert property (state_q == dis_pkg::ST_TP1 && !jump_target_phase |=>
        display_program_counter_q == $past(display_program_counter_q) + 16'h0002)
        else $error("program counter not advanced by two");
    a_req_addr: assert property (state_q == dis_pkg::ST_TP1 |=> dma_req_o &&
        bus_addr_o == display_program_counter_q)
        else $error("request or address wrong at step two");
    a_flag_timing: assert property ($rose(dma_req_o) && jump_decoded_o &&
        !second_word_flag_o |-> !second_word_flag_o ##2 second_word_flag_o)
        else $error("second-word flag not set 50 ns after request");
    a_mode_hold: assert property (state_q == dis_pkg::ST_LMODE && jump_target_phase |=>
        $stable(ctrl_mode_q) && $stable(data_mode_q) && $stable(control_word_flag_o)
        && second_word_flag_o)
        else $error("modes changed in jump target phase");
    a_target_load: assert property (s_target_load |=> display_program_counter_q ==
        {$past(word_q[15:1]), 1'b0} ##1 $stable(display_program_counter_q))
        else $error("jump target not loaded or advanced");
    a_target_end: assert property (s_target_load ##1 1'b1 ##1 dma_req_o ##1 1'b1
        |=> !second_word_flag_o)
        else $error("second-word flag not cleared after target");
    a_one_req: assert property (dma_req_o && state_q == dis_pkg::ST_WAIT |=>
        state_q != dis_pkg::ST_LMODE || !dma_req_o)
        else $error("mode load without fetched word");
    a_preset: assert property (preset_rise |=> line_cnt_q == 4'hf)
        else $error("line counter not preset");
    a_solid: assert property (vint_sync_q[1] && !line_select_low_o &&
        !line_select_high_o |=> intensity_level_o)
        else $error("solid line not on");
endmodule
`default_nettype wire

// ### testbench/dis_memory_model.sv
// Memory model answering the sequencer's word fetches
`default_nettype none
module dis_memory_model (
    // Clock
    input wire logic clk_i,
    // Fetch request side
    input wire logic dma_req_i,
    input wire logic [15:0] addr_i,
    input wire logic [3:0] delay_i,
    // Word return side
    output logic valid_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:127];
    initial begin
        valid_o = 1'b0;
        data_o = 16'h0000;
        for (int i = 0; i < 128; i++) begin
            mem[i] = 16'h0000;
        end
        // One process drives both return signals
        forever begin
            @(posedge clk_i);
            if (dma_req_i) begin
                repeat (delay_i) @(posedge clk_i);
                data_o <= mem[addr_i[7:1]];
                @(posedge clk_i);
                valid_o <= 1'b1;
                while (dma_req_i) @(posedge clk_i);
                @(posedge clk_i);
                valid_o <= 1'b0;
                // Released data lines do not keep the last word
                data_o <= ~data_o;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/dis_sequencer_bench.sv
// Self-checking bench for the display instruction sequencer
`default_nettype none
module dis_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic dma_req_o, fetch_word_valid_i;
    logic [15:0] bus_addr_o, bus_data_i;
    logic line_counter_preset_i = 1'b0;
    logic vector_step_clock_i = 1'b0;
    logic vector_intensity_flag_i = 1'b0;
    logic jump_decoded_o, nop_decoded_o, graphic_mode_decoded_o, control_word_flag_o;
    logic second_word_flag_o, line_select_low_o, line_select_high_o, blink_enable_flag_o;
    logic pen_interrupt_enable_o, intensity_level_o;
    logic [6:0] data_mode_o;
    logic [2:0] intensity_o;
    logic [3:0] mem_delay = 4'h2;
    logic [31:0] d;
    int n_mismatch = 0;
    int total_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    dis_sequencer #(.ADDR_W(16)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .dma_req_o(dma_req_o),
        .bus_addr_o(bus_addr_o), .fetch_word_valid_i(fetch_word_valid_i),
        .bus_data_i(bus_data_i), .line_counter_preset_i(line_counter_preset_i),
        .vector_step_clock_i(vector_step_clock_i),
        .vector_intensity_flag_i(vector_intensity_flag_i), .jump_decoded_o(jump_decoded_o),
        .nop_decoded_o(nop_decoded_o), .graphic_mode_decoded_o(graphic_mode_decoded_o),
        .data_mode_o(data_mode_o), .control_word_flag_o(control_word_flag_o),
        .second_word_flag_o(second_word_flag_o), .line_select_low_o(line_select_low_o),
        .line_select_high_o(line_select_high_o), .blink_enable_flag_o(blink_enable_flag_o),
        .pen_interrupt_enable_o(pen_interrupt_enable_o), .intensity_o(intensity_o),
        .intensity_level_o(intensity_level_o));
    dis_memory_model MEM (.clk_i(clk_sys_i), .dma_req_i(dma_req_o), .addr_i(bus_addr_o),
        .delay_i(mem_delay), .valid_o(fetch_word_valid_i), .data_o(bus_data_i));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (dma_req_o !== lvl && n < 300) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Next fetch request, its address, then let the step-two end land
    task automatic step(input logic [15:0] a);
        wait_req(1'b0);
        wait_req(1'b1);
        check(bus_addr_o, a);
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic clocks(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    initial begin
        clocks(2);
        rst_n_i <= 1'b1;
        clocks(1);
        reg_read(4'h4, d);
        check(d, 32'h0000f000);
        reg_read(4'hc, d);
        check(d, 32'h0);
        vector_intensity_flag_i <= 1'b1;
        clocks(6);
        check(intensity_level_o, 1'b1);
        MEM.mem[8'h08] = 16'h96fe;
        MEM.mem[8'h09] = 16'he800;
        MEM.mem[8'h0a] = 16'he000;
        MEM.mem[8'h0b] = 16'h8041;
        MEM.mem[8'h20] = 16'h0123;
        MEM.mem[8'h21] = 16'ha810;
        reg_write(4'h0, 32'h00000010);
        reg_write(4'h8, 32'h00000080);
        check({dma_req_o, bus_addr_o}, 17'h10010);
        step(16'h0012);
        check({graphic_mode_decoded_o, control_word_flag_o, data_mode_o}, 9'h180);
        check({intensity_o, blink_enable_flag_o, pen_interrupt_enable_o}, 5'h17);
        check({line_select_high_o, line_select_low_o}, 2'h2);
        step(16'h0014);
        check({nop_decoded_o, jump_decoded_o}, 2'h2);
        mem_delay <= 4'h9;
        step(16'h0016);
        check({jump_decoded_o, second_word_flag_o}, 2'h3);
        step(16'h8040);
        check({second_word_flag_o, control_word_flag_o, jump_decoded_o}, 3'h3);
        step(16'h8042);
        check({graphic_mode_decoded_o, control_word_flag_o, data_mode_o}, 9'h004);
        step(16'h8044);
        check({intensity_o, blink_enable_flag_o, data_mode_o}, 11'h500);
        check(graphic_mode_decoded_o, 1'b1);
        line_counter_preset_i <= 1'b1;
        clocks(3);
        line_counter_preset_i <= 1'b0;
        clocks(5);
        reg_read(4'h4, d);
        check(d[15:12], 4'hf);
        check(intensity_level_o, 1'b1);
        for (int i = 0; i < 8; i++) begin
            vector_step_clock_i <= 1'b1;
            clocks(3);
            vector_step_clock_i <= 1'b0;
            clocks(3);
        end
        clocks(3);
        reg_read(4'h4, d);
        check(d[15:12], 4'hb);
        check(intensity_level_o, 1'b0);
        vector_intensity_flag_i <= 1'b0;
        line_counter_preset_i <= 1'b1;
        clocks(6);
        check(intensity_level_o, 1'b0);
        reg_read(4'h4, d);
        check(d[15:12], 4'hf);
        tally_and_finish();
    end
endmodule
`default_nettype wire
